/* File: rtl/frf_engine_end.sv */
// module: protocol engine side that offers frames over the link
`timescale 1ns/1ps
module frf_engine_end (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// user side
	input wire logic send_req,
	input wire logic send_mb_hit,
	input wire logic [frf_pkg::FID_W-1:0] send_id,
	input wire logic [frf_pkg::MID_W-1:0] send_msg_id,
	input wire frf_pkg::frf_status_s send_status,
	input wire logic in_config,
	output logic send_busy,
	// link
	frf_link_if.engine link
);
	// frame offered after the buffer search result is final
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.frame_vld <= 1'b0;
			link.mb_hit <= 1'b0;
			link.frame_id <= '0;
			link.msg_id <= '0;
			link.status <= '0;
		end else if (link.frame_vld && !link.frame_rdy) begin
			link.frame_vld <= 1'b1;
		end else if (send_req) begin
			link.frame_vld <= 1'b1;
			link.mb_hit <= send_mb_hit;
			link.frame_id <= send_id;
			link.msg_id <= send_msg_id;
			link.status <= send_status;
		end else begin
			link.frame_vld <= 1'b0;
		end
	end

	// configuration state gates software queue setup
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.config_state <= 1'b1;
		end else begin
			link.config_state <= in_config;
		end
	end

	assign send_busy = link.frame_vld && !link.frame_rdy;
endmodule : frf_engine_end

/* File: rtl/frf_queue_dev.sv */
// module: two channel receive queues with filter path and apb registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// Function
// - two independent queues, channel a and b
// - layout programmed only in configuration state
// - software sets depth of at least two
// - filter path only when no buffer matched
// - store entry, advance write index, set flag
// - read index points at oldest valid entry
// - write one advances read index, clears flag once queue is empty
// - read index wraps to start index
// - only non-null frames are filtered; invalid frames that pass are still written to memory but not committed
// - append only when all three filters pass
// - reject filter passes on masked id mismatch
// - value zero, full mask rejects id zero
// - zero mask rejects all; reset value
// - four range filters with enable, mode
// - id inside enabled rejection range rejects
// - no acceptance enabled or one matches
// - message id filter only dynamic ppi frames
// - masked message id equals masked value
module frf_queue_dev #(
	parameter int IDX_W = frf_pkg::IDX_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// frame memory write port
	output logic mem_we,
	output logic [IDX_W-1:0] mem_hdr_idx,
	output logic mem_chan_b,
	// link
	frf_link_if.device link
);
	localparam int N = frf_pkg::NUM_RANGE;
	localparam int FW = frf_pkg::FID_W;
	localparam int MW = frf_pkg::MID_W;

	////////////////////////////////////////////////////////////////
	logic [IDX_W-1:0] start_reg [2];
	logic [IDX_W-1:0] depth_reg [2];
	logic [IDX_W-1:0] rd_reg [2];
	logic [IDX_W-1:0] wr_reg [2];
	logic [1:0] ne_reg;
	logic [1:0] mask_reg;
	logic [FW-1:0] rej_val_reg;
	logic [FW-1:0] rej_msk_reg;
	logic [2*N-1:0] rng_ctl_reg;
	logic [2*FW-1:0] rng_bnd_reg [N];
	logic [MW-1:0] mid_val_reg;
	logic [MW-1:0] mid_msk_reg;
	logic wr_en;
	logic [1:0] clr_ne;
	logic [1:0] app;
	logic pass_all;
	logic chan;

	// wrap to start after the last entry of the queue
	function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] cur,
			input logic [IDX_W-1:0] st, input logic [IDX_W-1:0] dp);
		logic [IDX_W-1:0] last;
		last = st + dp - 1'b1;
		next_idx = (cur == last) ? st : cur + 1'b1;
	endfunction : next_idx

	////////////////////////////////////////////////////////////////
	// filter path
	logic rej_pass;
	logic rng_rej_pass;
	logic rng_acc_pass;
	logic mid_pass;
	logic [N-1:0] in_rng;
	logic [N-1:0] rej_on;
	logic [N-1:0] acc_on;

	generate
		for (genvar i = 0; i < N; i++) begin : g_rng
			assign in_rng[i] = (rng_bnd_reg[i][FW-1:0] <= link.frame_id) &&
				(link.frame_id <= rng_bnd_reg[i][2*FW-1:FW]);
			assign rej_on[i] = rng_ctl_reg[i] && rng_ctl_reg[frf_pkg::RNG_MODE_POS+i];
			assign acc_on[i] = rng_ctl_reg[i] && !rng_ctl_reg[frf_pkg::RNG_MODE_POS+i];
		end
	endgenerate

	// zero mask makes both sides equal, so nothing passes
	assign rej_pass = (link.frame_id & rej_msk_reg) != (rej_val_reg & rej_msk_reg);
	assign rng_rej_pass = ~|(rej_on & in_rng);
	assign rng_acc_pass = (acc_on == '0) || |(acc_on & in_rng);
	assign mid_pass = !(link.status.dynamic && link.status.ppi) ||
		((link.msg_id & mid_msk_reg) == (mid_val_reg & mid_msk_reg));
	assign pass_all = rej_pass && rng_rej_pass && rng_acc_pass && mid_pass;

	// invalid frames still written but never committed
	assign chan = link.status.chan_b;
	assign link.frame_rdy = 1'b1;
	always_comb begin
		app = 2'b00;
		if (link.frame_vld && !link.mb_hit && !link.status.null_frame && pass_all) begin
			app[chan] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_we <= 1'b0;
			mem_hdr_idx <= '0;
			mem_chan_b <= 1'b0;
		end else begin
			mem_we <= |app;
			mem_hdr_idx <= wr_reg[chan];
			mem_chan_b <= chan;
		end
	end

	////////////////////////////////////////////////////////////////
	// per-channel index and flag state
	assign wr_en = psel && penable && pwrite;
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			assign clr_ne[c] = wr_en && paddr == frf_pkg::OFS_STATUS && pwdata[c] && ne_reg[c];
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					wr_reg[c] <= '0;
					rd_reg[c] <= '0;
					ne_reg[c] <= 1'b0;
				end else if (link.config_state) begin
					wr_reg[c] <= start_reg[c];
					rd_reg[c] <= start_reg[c];
					ne_reg[c] <= 1'b0;
				end else begin
					if (app[c] && link.status.valid) begin
						wr_reg[c] <= next_idx(wr_reg[c], start_reg[c], depth_reg[c]);
					end
					if (clr_ne[c]) begin
						rd_reg[c] <= next_idx(rd_reg[c], start_reg[c], depth_reg[c]);
					end
					// a new entry wins over the clear; flag also stays while entries remain
					if (app[c] && link.status.valid) begin
						ne_reg[c] <= 1'b1;
					end else if (clr_ne[c]) begin
						ne_reg[c] <= (next_idx(rd_reg[c], start_reg[c], depth_reg[c]) != wr_reg[c]);
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// apb configuration registers; layout only while in configuration
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_reg[0] <= '0;
			start_reg[1] <= '0;
			depth_reg[0] <= frf_pkg::DEPTH_RST;
			depth_reg[1] <= frf_pkg::DEPTH_RST;
		end else if (wr_en && link.config_state) begin
			unique case (paddr)
				frf_pkg::OFS_START_A: start_reg[0] <= pwdata[IDX_W-1:0];
				frf_pkg::OFS_DEPTH_A: depth_reg[0] <= pwdata[IDX_W-1:0];
				frf_pkg::OFS_START_B: start_reg[1] <= pwdata[IDX_W-1:0];
				frf_pkg::OFS_DEPTH_B: depth_reg[1] <= pwdata[IDX_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_reg <= '0;
			rej_val_reg <= '0;
			rej_msk_reg <= frf_pkg::REJ_MSK_RST;
			rng_ctl_reg <= '0;
			mid_val_reg <= '0;
			mid_msk_reg <= frf_pkg::MID_MSK_RST;
		end else if (wr_en) begin
			unique case (paddr)
				frf_pkg::OFS_IRQ_MASK: mask_reg <= pwdata[1:0];
				frf_pkg::OFS_REJ_VAL: rej_val_reg <= pwdata[FW-1:0];
				frf_pkg::OFS_REJ_MSK: rej_msk_reg <= pwdata[FW-1:0];
				frf_pkg::OFS_RNG_CTL: rng_ctl_reg <= pwdata[2*N-1:0];
				frf_pkg::OFS_MID_VAL: mid_val_reg <= pwdata[MW-1:0];
				frf_pkg::OFS_MID_MSK: mid_msk_reg <= pwdata[MW-1:0];
				default: ;
			endcase
		end
	end

	generate
		for (genvar i = 0; i < N; i++) begin : g_bnd
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					rng_bnd_reg[i] <= '0;
				end else if (wr_en && paddr == frf_pkg::OFS_RNG_BND0 + 8'(4*i)) begin
					rng_bnd_reg[i] <= pwdata[2*FW-1:0];
				end
			end
		end
	endgenerate

	// read mux; slave answers in the access phase, no wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	always_comb begin
		prdata = 32'h0;
		unique case (paddr)
			frf_pkg::OFS_STATUS: prdata = {30'h0, ne_reg};
			frf_pkg::OFS_IRQ_MASK: prdata = {30'h0, mask_reg};
			frf_pkg::OFS_START_A: prdata = 32'(start_reg[0]);
			frf_pkg::OFS_DEPTH_A: prdata = 32'(depth_reg[0]);
			frf_pkg::OFS_START_B: prdata = 32'(start_reg[1]);
			frf_pkg::OFS_DEPTH_B: prdata = 32'(depth_reg[1]);
			frf_pkg::OFS_QUEUE_READ_INDEX_A: prdata = 32'(rd_reg[0]);
			frf_pkg::OFS_QUEUE_READ_INDEX_B: prdata = 32'(rd_reg[1]);
			frf_pkg::OFS_WRIDX_A: prdata = 32'(wr_reg[0]);
			frf_pkg::OFS_WRIDX_B: prdata = 32'(wr_reg[1]);
			frf_pkg::OFS_REJ_VAL: prdata = 32'(rej_val_reg);
			frf_pkg::OFS_REJ_MSK: prdata = 32'(rej_msk_reg);
			frf_pkg::OFS_RNG_CTL: prdata = 32'(rng_ctl_reg);
			frf_pkg::OFS_MID_VAL: prdata = 32'(mid_val_reg);
			frf_pkg::OFS_MID_MSK: prdata = 32'(mid_msk_reg);
			default: begin
				for (int i = 0; i < N; i++) begin
					if (paddr == frf_pkg::OFS_RNG_BND0 + 8'(4*i)) begin
						prdata = 32'(rng_bnd_reg[i]);
					end
				end
			end
		endcase
	end

	assign irq = |(ne_reg & mask_reg);
endmodule : frf_queue_dev

/* File: shared/frf_link_if.sv */
// interface: received frame delivery from protocol engine to queue filter
`timescale 1ns/1ps
interface frf_link_if;
	logic frame_vld;
	logic frame_rdy;
	logic mb_hit;
	logic [frf_pkg::FID_W-1:0] frame_id;
	logic [frf_pkg::MID_W-1:0] msg_id;
	frf_pkg::frf_status_s status;
	logic config_state;
	modport device (input frame_vld, mb_hit, frame_id, msg_id, status, config_state, output frame_rdy);
	modport engine (output frame_vld, mb_hit, frame_id, msg_id, status, config_state, input frame_rdy);
endinterface : frf_link_if

/* File: shared/frf_pkg.sv */
// package: constants and types shared by the receive queue filter ends
package frf_pkg;
	localparam int IDX_W = 7;
	localparam int FID_W = 11;
	localparam int MID_W = 16;
	localparam int NUM_RANGE = 4;
	// apb register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_START_A = 8'h0c;
	localparam logic [7:0] OFS_DEPTH_A = 8'h10;
	localparam logic [7:0] OFS_START_B = 8'h14;
	localparam logic [7:0] OFS_DEPTH_B = 8'h18;
	localparam logic [7:0] OFS_QUEUE_READ_INDEX_A = 8'h1c;
	localparam logic [7:0] OFS_QUEUE_READ_INDEX_B = 8'h20;
	localparam logic [7:0] OFS_WRIDX_A = 8'h24;
	localparam logic [7:0] OFS_WRIDX_B = 8'h28;
	localparam logic [7:0] OFS_REJ_VAL = 8'h2c;
	localparam logic [7:0] OFS_REJ_MSK = 8'h30;
	localparam logic [7:0] OFS_RNG_CTL = 8'h34;
	localparam logic [7:0] OFS_RNG_BND0 = 8'h38;
	localparam logic [7:0] OFS_MID_VAL = 8'h48;
	localparam logic [7:0] OFS_MID_MSK = 8'h4c;
	// status bit positions (also mask layout)
	localparam int ST_NE_A = 0;
	localparam int ST_NE_B = 1;
	// range control: enable bit i, mode bit 4+i
	localparam int RNG_MODE_POS = 4;
	// reset values
	localparam logic [FID_W-1:0] REJ_MSK_RST = 11'h000;
	localparam logic [MID_W-1:0] MID_MSK_RST = 16'h0000;
	localparam logic [IDX_W-1:0] DEPTH_RST = 7'h02;
	// frame status codes from the protocol engine
	typedef struct packed {
		logic valid;
		logic null_frame;
		logic dynamic;
		logic ppi;
		logic chan_b;
	} frf_status_s;
endpackage : frf_pkg

/* File: tb/frf_link_monitor.sv */
// checker: link and frame memory write relations
`timescale 1ns/1ps
module frf_link_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// link
	input wire logic frame_vld,
	input wire logic frame_rdy,
	input wire logic mb_hit,
	input wire frf_pkg::frf_status_s status,
	input wire logic config_state,
	// memory write
	input wire logic mem_we,
	input wire logic mem_chan_b
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	chk_rdy_high: assert property (frame_rdy) else $error("link not ready");
	chk_reset_quiet: assert property ($fell(sys_rst) |-> !mem_we && !frame_vld && config_state)
		else $error("bad state after reset");
	chk_hit_drop: assert property (frame_vld && mb_hit |=> !mem_we)
		else $error("buffer hit frame written");
	chk_null_drop: assert property (frame_vld && status.null_frame |=> !mem_we)
		else $error("null frame written");
	chk_we_cause: assert property (mem_we |-> $past(frame_vld) && !$past(mb_hit))
		else $error("write without frame");
	chk_idle_quiet: assert property ((!frame_vld) [*2] |-> !mem_we)
		else $error("write while idle");
	chk_chan_a_route: assert property (mem_we && !mem_chan_b |-> !$past(status.chan_b))
		else $error("channel b frame in queue a");
	chk_chan_b_route: assert property (mem_we && mem_chan_b |-> $past(status.chan_b))
		else $error("channel a frame in queue b");
	// main scenarios reached
	cover property (mem_we && mem_chan_b);
	cover property (mem_we && !mem_chan_b);
	cover property (frame_vld && mb_hit);
endmodule : frf_link_monitor

/* File: tb/testbench.sv */
// testbench: both ends joined over the link, checked through apb
`timescale 1ns/1ps
module testbench;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, mem_we, mem_chan_b;
	logic send_req, send_mb_hit, in_config, send_busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic we, busy, qerr;
	logic [7:0] hdr;
	logic [frf_pkg::IDX_W-1:0] mem_hdr_idx;
	logic [frf_pkg::FID_W-1:0] send_id;
	logic [frf_pkg::MID_W-1:0] send_msg_id;
	frf_pkg::frf_status_s send_status;
	// status codes: valid,null,dynamic,ppi,chan_b
	localparam frf_pkg::frf_status_s SA = 5'h10, SB = 5'h11, SP = 5'h12, DP = 5'h16, NUL = 5'h18, BAD = 5'h00;
	int n_fail, checked;
	frf_link_if link ();
	frf_engine_end frf_engine_end_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .send_req(send_req),
		.send_mb_hit(send_mb_hit), .send_id(send_id), .send_msg_id(send_msg_id), .send_status(send_status),
		.in_config(in_config), .send_busy(send_busy), .link(link.engine));
	frf_queue_dev frf_queue_dev_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .mem_we(mem_we), .mem_hdr_idx(mem_hdr_idx), .mem_chan_b(mem_chan_b), .link(link.device));
	frf_link_monitor frf_link_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .frame_vld(link.frame_vld),
		.frame_rdy(link.frame_rdy), .mb_hit(link.mb_hit), .status(link.status),
		.config_state(link.config_state), .mem_we(mem_we), .mem_chan_b(mem_chan_b));
	////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// no wait-state count assumed: only the watchdog ends a stuck access
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		q = prdata;
		qerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		cmp(nm, e, q);
	endtask : rd
	task automatic frame_memory(input logic [10:0] id, input logic [15:0] mid, input frf_pkg::frf_status_s st,
		input logic hit);
		@(posedge ref_clk);
		send_req <= 1'b1;
		send_id <= id;
		send_msg_id <= mid;
		send_status <= st;
		send_mb_hit <= hit;
		@(posedge ref_clk);
		send_req <= 1'b0;
		repeat (2) @(posedge ref_clk);
		// write strobe stands one cycle only; take it here before it drops
		we = mem_we;
		hdr = {mem_chan_b, mem_hdr_idx};
		busy = send_busy;
		@(posedge ref_clk);
	endtask : frame_memory
	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, send_req, send_mb_hit, paddr, pwdata, send_id, send_msg_id} = '0;
		send_status = BAD;
		in_config = 1'b1;
		sys_rst = 1'b1;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd("rej_msk", frf_pkg::OFS_REJ_MSK, 32'h0);
		rd("depth_a", frf_pkg::OFS_DEPTH_A, 32'h2);
		wr(frf_pkg::OFS_START_A, 32'h8);
		wr(frf_pkg::OFS_DEPTH_A, 32'h4);
		wr(frf_pkg::OFS_START_B, 32'h14);
		in_config <= 1'b0;
		repeat (2) @(posedge ref_clk);
		frame_memory(11'h005, 16'h0, SA, 1'b0);
		rd("status", frf_pkg::OFS_STATUS, 32'h0);
		$display("reject all done");
		wr(frf_pkg::OFS_REJ_MSK, 32'h7ff);
		frame_memory(11'h000, 16'h0, SA, 1'b0);
		rd("status", frf_pkg::OFS_STATUS, 32'h0);
		frame_memory(11'h005, 16'h0, SA, 1'b0);
		cmp("mem_we", 32'h1, {31'h0, we});
		cmp("mem_hdr_idx", 32'h08, {24'h0, hdr});
		cmp("send_busy", 32'h0, {31'h0, busy});
		rd("status", frf_pkg::OFS_STATUS, 32'h1);
		frame_memory(11'h006, 16'h0, NUL, 1'b0);
		cmp("mem_we", 32'h0, {31'h0, we});
		frame_memory(11'h006, 16'h0, BAD, 1'b0);
		cmp("mem_we", 32'h1, {31'h0, we});
		cmp("mem_hdr_idx", 32'h09, {24'h0, hdr});
		frame_memory(11'h006, 16'h0, SA, 1'b1);
		cmp("mem_we", 32'h0, {31'h0, we});
		wr(frf_pkg::OFS_REJ_VAL, 32'h6);
		frame_memory(11'h006, 16'h0, SA, 1'b0);
		cmp("mem_we", 32'h0, {31'h0, we});
		rd("wridx_a", frf_pkg::OFS_WRIDX_A, 32'h9);
		$display("value mask done");
		wr(frf_pkg::OFS_RNG_CTL, 32'h11);
		wr(frf_pkg::OFS_RNG_BND0, 32'h0000a00a);
		frame_memory(11'h00f, 16'h0, SA, 1'b0);
		cmp("mem_we", 32'h0, {31'h0, we});
		frame_memory(11'h015, 16'h0, SA, 1'b0);
		rd("wridx_a", frf_pkg::OFS_WRIDX_A, 32'ha);
		wr(frf_pkg::OFS_RNG_CTL, 32'h02);
		wr(frf_pkg::OFS_RNG_BND0 + 8'h04, 32'h0001401e);
		frame_memory(11'h019, 16'h0, SA, 1'b0);
		cmp("mem_we", 32'h0, {31'h0, we});
		frame_memory(11'h01e, 16'h0, SA, 1'b0);
		rd("wridx_a", frf_pkg::OFS_WRIDX_A, 32'hb);
		$display("range done");
		wr(frf_pkg::OFS_STATUS, 32'h1);
		rd("queue_read_index_a", frf_pkg::OFS_QUEUE_READ_INDEX_A, 32'h9);
		rd("status", frf_pkg::OFS_STATUS, 32'h1);
		wr(frf_pkg::OFS_STATUS, 32'h1);
		wr(frf_pkg::OFS_STATUS, 32'h1);
		rd("status", frf_pkg::OFS_STATUS, 32'h0);
		wr(frf_pkg::OFS_RNG_CTL, 32'h0);
		wr(frf_pkg::OFS_MID_VAL, 32'h1234);
		wr(frf_pkg::OFS_MID_MSK, 32'hffff);
		frame_memory(11'h028, 16'h1235, SP, 1'b0);
		frame_memory(11'h029, 16'h1235, DP, 1'b0);
		cmp("mem_we", 32'h0, {31'h0, we});
		frame_memory(11'h02a, 16'h1234, DP, 1'b0);
		rd("wridx_a", frf_pkg::OFS_WRIDX_A, 32'h9);
		wr(frf_pkg::OFS_STATUS, 32'h1);
		rd("queue_read_index_a", frf_pkg::OFS_QUEUE_READ_INDEX_A, 32'h8);
		$display("message id done");
		wr(frf_pkg::OFS_IRQ_MASK, 32'h2);
		frame_memory(11'h007, 16'h0, SB, 1'b0);
		cmp("mem_hdr_idx", 32'h94, {24'h0, hdr});
		rd("wridx_b", frf_pkg::OFS_WRIDX_B, 32'h15);
		rd("wridx_a", frf_pkg::OFS_WRIDX_A, 32'h9);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(frf_pkg::OFS_STATUS, 32'h2);
		rd("queue_read_index_b", frf_pkg::OFS_QUEUE_READ_INDEX_B, 32'h15);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(frf_pkg::OFS_START_A, 32'h3);
		rd("start_a", frf_pkg::OFS_START_A, 32'h8);
		rd("unmapped", 8'h80, 32'h0);
		cmp("pslverr", 32'h0, {31'h0, qerr});
		$display("channel and irq done");
		close_out();
	end
endmodule : testbench
